/* rtl/ate_top.sv */
// Acquisition trigger gating, encoder divider, camera-control retiming
// and counter readback, reached over AXI4-Lite.
// Assumes counters and camera-control levels come from logic on aclk;
// pixel clocks, trigger and encoder pins are asynchronous.
`timescale 1ns/1ps
`include "ate_map.svh"

module ate_top
  import ate_pkg::*;
#(
  parameter int VTA_W = 17,
  parameter int DIV_W = 10,
  parameter int CC_W = 4,
  parameter bit ALT_DIVIDER = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`ATE_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`ATE_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Counters from the control-table engines
  input wire logic [VTA_W-1:0] vertical_table_address,
  input wire logic frame_end,
  input wire logic [1:0] horizontal_counter_low_bits,
  // External pins
  input wire logic [2:0] trigger_pins,
  input wire logic [2:0] encoder_pins,
  input wire logic primary_pixel_clock,
  input wire logic secondary_pixel_clock,
  // Camera-control levels and outputs
  input wire logic [CC_W-1:0] cc_primary_in,
  input wire logic [CC_W-1:0] cc_secondary_in,
  output logic [CC_W-1:0] cc_primary_out,
  output logic [CC_W-1:0] cc_secondary_out,
  // Acquisition side
  output logic acq_trigger,
  output logic encoder_pulse,
  output logic [DIV_W-1:0] encoder_divider_m_param
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ate_wr_state_t wr_state_q, wr_state_d;
  ate_rd_state_t rd_state_q, rd_state_d;
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [`ATE_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  ate_resp_t bresp_q, bresp_d;
  ate_resp_t rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] rb_q, rb_d;
  logic [VTA_W-1:0] held_line_q, held_line_d;
  logic [31:0] lane_mask;
  logic [31:0] readback_view;
  logic do_write;
  logic [2:0] trig_sync;
  logic [2:0] enc_sync;
  logic [1:0] pclk_sync;
  logic [1:0] pclk_prev_q, pclk_prev_d;
  logic [1:0] pclk_rise;
  logic [CC_W-1:0] cc_pri_q, cc_pri_d;
  logic [CC_W-1:0] cc_sec_q, cc_sec_d;
  ate_sync_code_t sync_code;
  logic trig_sel_level;
  logic trig_hw_active;
  logic trig_q, trig_d;
  logic enc_sel_level;
  logic enc_level;
  logic enc_prev_q, enc_prev_d;
  logic enc_edge;
  logic [DIV_W-1:0] div_field;
  logic [DIV_W-1:0] div_ratio;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  ate_sync2 #(.WIDTH(3)) u_trig_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(trigger_pins),
    .sync_out(trig_sync)
  );

  ate_sync2 #(.WIDTH(3)) u_enc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(encoder_pins),
    .sync_out(enc_sync)
  );

  ate_sync2 #(.WIDTH(2)) u_pclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({secondary_pixel_clock, primary_pixel_clock}),
    .sync_out(pclk_sync)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data are taken in either order; the answer waits for both
  assign s_axi_awready = !aw_held_q && (wr_state_q == WR_COLLECT);
  assign s_axi_wready = !w_held_q && (wr_state_q == WR_COLLECT);
  assign s_axi_bvalid = (wr_state_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign do_write = (wr_state_q == WR_COLLECT) && aw_held_q && w_held_q;

  always_comb begin
    lane_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wr_state_d = wr_state_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    unique case (wr_state_q)
      WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        if (do_write) begin
          aw_held_d = 1'b0;
          w_held_d = 1'b0;
          wr_state_d = WR_RESP;
          if ((awaddr_q[`ATE_ADDR_W-1:2] == `ATE_CTRL_OFS >> 2) ||
              (awaddr_q[`ATE_ADDR_W-1:2] == `ATE_READBACK_OFS >> 2)) begin
            bresp_d = `ATE_RESP_OKAY;
          end else begin
            bresp_d = `ATE_RESP_DECERR;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_d = WR_COLLECT;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Control and readback storage
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    rb_d = rb_q;
    if (do_write && awaddr_q[`ATE_ADDR_W-1:2] == `ATE_CTRL_OFS >> 2) begin
      ctrl_d = (ctrl_q & ~(lane_mask & `ATE_CTRL_WMASK)) |
               (wdata_q & lane_mask & `ATE_CTRL_WMASK);
    end
    // Only the hold bit and divider field store; counter, state and top bit
    // are read-only views, so writes to them are dropped
    if (do_write && awaddr_q[`ATE_ADDR_W-1:2] == `ATE_READBACK_OFS >> 2) begin
      rb_d = (rb_q & ~(lane_mask & `ATE_RB_WMASK)) |
             (wdata_q & lane_mask & `ATE_RB_WMASK);
    end
  end

  // ---------------------------------------------------------------
  // Last-active-line capture
  // ---------------------------------------------------------------
  always_comb begin
    held_line_d = held_line_q;
    if (frame_end) begin
      held_line_d = vertical_table_address;
    end
  end

  always_comb begin
    readback_view = '0;
    if (rb_q[`ATE_RB_HOLD]) begin
      readback_view[`ATE_RB_VTA_HI:0] = held_line_q;
    end else begin
      readback_view[`ATE_RB_VTA_HI:0] = vertical_table_address;
    end
    readback_view[`ATE_RB_HOLD] = rb_q[`ATE_RB_HOLD];
    readback_view[`ATE_RB_DIV_HI:`ATE_RB_DIV_LO] = div_field;
    // Live low bits; software polls them to see horizontal activity
    readback_view[`ATE_RB_HLOW_HI:`ATE_RB_HLOW_LO] = horizontal_counter_low_bits;
    readback_view[`ATE_RB_TSTATE] = trig_sel_level;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = (rd_state_q == RD_IDLE);
  assign s_axi_rvalid = (rd_state_q == RD_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rd_state_q)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_d = RD_DATA;
          rresp_d = `ATE_RESP_OKAY;
          if (s_axi_araddr[`ATE_ADDR_W-1:2] == `ATE_CTRL_OFS >> 2) begin
            rdata_d = ctrl_q;
          end else if (s_axi_araddr[`ATE_ADDR_W-1:2] == `ATE_READBACK_OFS >> 2) begin
            rdata_d = readback_view;
          end else begin
            rdata_d = '0;
            rresp_d = `ATE_RESP_DECERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_d = RD_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Trigger path
  // ---------------------------------------------------------------
  always_comb begin
    trig_sel_level = 1'b0;
    unique case (ctrl_q[`ATE_CTRL_TSEL_HI:`ATE_CTRL_TSEL_LO])
      2'h0: trig_sel_level = trig_sync[0];
      2'h1: trig_sel_level = trig_sync[1];
      2'h2: trig_sel_level = trig_sync[2];
      2'h3: trig_sel_level = 1'b0;
    endcase
    // Polarity applies to the pin only, never to the software bit
    trig_hw_active = trig_sel_level ^ ctrl_q[`ATE_CTRL_TPOL];
    trig_d = (ctrl_q[`ATE_CTRL_TGATE] & trig_hw_active) |
             ctrl_q[`ATE_CTRL_SWTRIG];
  end

  // ---------------------------------------------------------------
  // Encoder path
  // ---------------------------------------------------------------
  always_comb begin
    enc_sel_level = 1'b0;
    unique case (ctrl_q[`ATE_CTRL_ESEL_HI:`ATE_CTRL_ESEL_LO])
      2'h0: enc_sel_level = enc_sync[0];
      2'h1: enc_sel_level = enc_sync[1];
      2'h2: enc_sel_level = enc_sync[2];
      2'h3: enc_sel_level = 1'b0;
    endcase
    enc_level = (ctrl_q[`ATE_CTRL_EGATE] & (enc_sel_level ^ ctrl_q[`ATE_CTRL_EPOL])) |
                ctrl_q[`ATE_CTRL_SWENC];
    enc_prev_d = enc_level;
    enc_edge = enc_level & ~enc_prev_q;
  end

  assign div_field = rb_q[`ATE_RB_DIV_HI:`ATE_RB_DIV_LO];
  // The alternative variant hands the field to its own divider as M
  assign div_ratio = ALT_DIVIDER ? DIV_W'(1) : div_field;
  assign encoder_divider_m_param = ALT_DIVIDER ? div_field : '0;

  ate_encoder_divide_ratio #(.WIDTH(DIV_W)) u_encoder_divide_ratio (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse_in(enc_edge),
    .ratio(div_ratio),
    .pulse_out(encoder_pulse)
  );

  // ---------------------------------------------------------------
  // Camera-control retiming
  // ---------------------------------------------------------------
  // Pixel clocks are sampled on aclk, so retiming is only exact for pixel
  // clocks well below half the aclk rate
  assign sync_code = ctrl_q[`ATE_CTRL_SYNC_HI:`ATE_CTRL_SYNC_LO];

  always_comb begin
    pclk_prev_d = pclk_sync;
    pclk_rise = pclk_sync & ~pclk_prev_q;
    cc_pri_d = cc_pri_q;
    cc_sec_d = cc_sec_q;
    unique case (sync_code)
      `ATE_SYNC_PRI: begin
        if (pclk_rise[0]) begin
          cc_pri_d = cc_primary_in;
          cc_sec_d = cc_secondary_in;
        end
      end
      `ATE_SYNC_SEC: begin
        if (pclk_rise[1]) begin
          cc_pri_d = cc_primary_in;
          cc_sec_d = cc_secondary_in;
        end
      end
      `ATE_SYNC_OWN: begin
        if (pclk_rise[0]) begin
          cc_pri_d = cc_primary_in;
        end
        if (pclk_rise[1]) begin
          cc_sec_d = cc_secondary_in;
        end
      end
      default: begin
        // Code 0, and reserved codes fall back to it
        cc_pri_d = cc_primary_in;
        cc_sec_d = cc_secondary_in;
      end
    endcase
  end

  assign cc_primary_out = cc_pri_q;
  assign cc_secondary_out = cc_sec_q;
  assign acq_trigger = trig_q;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_COLLECT;
      rd_state_q <= RD_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= `ATE_RESP_OKAY;
      rresp_q <= `ATE_RESP_OKAY;
      rdata_q <= '0;
      ctrl_q <= `ATE_CTRL_RST;
      rb_q <= `ATE_RB_RST;
      held_line_q <= '0;
      pclk_prev_q <= '0;
      cc_pri_q <= '0;
      cc_sec_q <= '0;
      trig_q <= 1'b0;
      enc_prev_q <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      rb_q <= rb_d;
      held_line_q <= held_line_d;
      pclk_prev_q <= pclk_prev_d;
      cc_pri_q <= cc_pri_d;
      cc_sec_q <= cc_sec_d;
      trig_q <= trig_d;
      enc_prev_q <= enc_prev_d;
    end
  end

endmodule : ate_top

/* inc/ate_map.svh */
// Register offsets, field positions and reset values of the acquisition
// trigger, encoder and readback block.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
`ifndef ATE_MAP_SVH
`define ATE_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ATE_CTRL_OFS 8'h00
`define ATE_READBACK_OFS 8'h04
`define ATE_ADDR_W 8

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ATE_CTRL_TSEL_LO 0
`define ATE_CTRL_TSEL_HI 1
`define ATE_CTRL_TPOL 2
`define ATE_CTRL_SWTRIG 3
`define ATE_CTRL_ESEL_LO 4
`define ATE_CTRL_ESEL_HI 5
`define ATE_CTRL_EPOL 6
`define ATE_CTRL_SWENC 7
`define ATE_CTRL_SYNC_LO 27
`define ATE_CTRL_SYNC_HI 29
`define ATE_CTRL_TGATE 30
`define ATE_CTRL_EGATE 31
`define ATE_CTRL_RST 32'h0000_0000
`define ATE_CTRL_WMASK 32'hF800_00FF

// ---------------------------------------------------------------
// Readback register fields
// ---------------------------------------------------------------
`define ATE_RB_VTA_HI 16
`define ATE_RB_HOLD 17
`define ATE_RB_DIV_LO 18
`define ATE_RB_DIV_HI 27
`define ATE_RB_HLOW_LO 28
`define ATE_RB_HLOW_HI 29
`define ATE_RB_TSTATE 30
`define ATE_RB_RST 32'h0000_0000
`define ATE_RB_WMASK 32'h0FFE_0000

// ---------------------------------------------------------------
// Synchronisation codes and bus answers
// ---------------------------------------------------------------
`define ATE_SYNC_NONE 3'h0
`define ATE_SYNC_PRI 3'h1
`define ATE_SYNC_SEC 3'h2
`define ATE_SYNC_OWN 3'h3
`define ATE_RESP_OKAY 2'h0
`define ATE_RESP_DECERR 2'h3

`endif

/* inc/ate_pkg.sv */
// Types shared by the acquisition trigger and encoder block.
// Assumes ate_map.svh supplies the numeric constants.
package ate_pkg;
  typedef logic [2:0] ate_sync_code_t;
  typedef logic [1:0] ate_resp_t;
  typedef enum logic [0:0] {WR_COLLECT, WR_RESP} ate_wr_state_t;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} ate_rd_state_t;
endpackage : ate_pkg

/* rtl/ate_sync2.sv */
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/1ps
module ate_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : ate_sync2

/* rtl/ate_encoder_divide_ratio.sv */
// Encoder pulse divider: one output pulse per N input pulses.
// Assumes pulse_in is a one-cycle pulse on aclk.
`timescale 1ns/1ps
module ate_encoder_divide_ratio #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pulses and ratio
  input wire logic pulse_in,
  input wire logic [WIDTH-1:0] ratio,
  output logic pulse_out
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic pulse_q;
  logic pulse_d;
  logic [WIDTH-1:0] last_cnt;

  always_comb begin
    // Ratio 0 behaves as 1
    last_cnt = (ratio > WIDTH'(1)) ? ratio - WIDTH'(1) : '0;
    count_d = count_q;
    pulse_d = 1'b0;
    if (count_q > last_cnt) begin
      // Ratio lowered mid-count: restart rather than wrap the counter
      count_d = '0;
    end else if (pulse_in) begin
      if (count_q == last_cnt) begin
        count_d = '0;
        pulse_d = 1'b1;
      end else begin
        count_d = count_q + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse_out = pulse_q;
endmodule : ate_encoder_divide_ratio

/* tb/ate_monitor.sv */
// Concurrent checks on the ports of the acquisition trigger block.
// Assumes one clock domain and the bench's single-access bus master.
`timescale 1ns/1ps
`include "ate_map.svh"
module ate_monitor #(
  parameter bit ALT_DIVIDER = 1'b0,
  parameter int DIV_W = 10
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ATE_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Block side
  input wire logic [1:0] horizontal_counter_low_bits,
  input wire logic encoder_pulse,
  input wire logic [DIV_W-1:0] encoder_divider_m_param
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Handshake steps
  // ---------------------------------------------------------------
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rb_read;
    rd_take ##0 s_axi_araddr[7:2] == 6'h01;
  endsequence

  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  unmapped_read_a: assert property (rd_take ##0 s_axi_araddr[7:3] != 5'h00 |=>
    s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read answer");
  hlow_read_a: assert property (rb_read |=>
    s_axi_rdata[29:28] == $past(horizontal_counter_low_bits)) else $error("horizontal bits");
  top_zero_a: assert property (rb_read |=> !s_axi_rdata[31])
    else $error("reserved top bit set");
  enc_single_a: assert property (encoder_pulse |=> !encoder_pulse)
    else $error("divided pulse too long");
  m_param_a: assert property (!ALT_DIVIDER |-> encoder_divider_m_param == '0)
    else $error("m parameter driven on plain divider");
endmodule : ate_monitor

bind ate_top ate_monitor #(.ALT_DIVIDER(ALT_DIVIDER), .DIV_W(DIV_W)) mon (.*);

/* tb/ate_far_side.sv */
// Model of the cameras and the trigger and encoder sources.
// Assumes its tasks are called from aclk edges; pins change after an edge.
`timescale 1ns/1ps
module ate_far_side (
  // Clock
  input wire logic aclk,
  // Pins toward the block
  output logic [2:0] trigger_pins,
  output logic [2:0] encoder_pins,
  output logic primary_pixel_clock,
  output logic secondary_pixel_clock
);
  // Pixel clocks stand still outside frames
  initial begin
    trigger_pins = 3'h0;
    encoder_pins = 3'h0;
    primary_pixel_clock = 1'b0;
    secondary_pixel_clock = 1'b0;
  end

  task automatic set_trig(input logic [2:0] v);
    @(posedge aclk);
    trigger_pins <= v;
  endtask : set_trig

  // Each level lasts 3 cycles, or the two-flop sampler could miss it
  task automatic pix_pulse(input logic [1:0] which);
    @(posedge aclk);
    primary_pixel_clock <= which[0];
    secondary_pixel_clock <= which[1];
    repeat (3) @(posedge aclk);
    primary_pixel_clock <= 1'b0;
    secondary_pixel_clock <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pix_pulse

  task automatic enc_pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      encoder_pins[0] <= 1'b1;
      repeat (4) @(posedge aclk);
      encoder_pins[0] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : enc_pulses
endmodule : ate_far_side

/* tb/tb_acq_trigger_encoder_status.sv */
// Self-checking bench: registers, trigger gating, encoder division, retiming.
// Assumes ate_far_side drives the pins and ate_monitor is bound to uut.
`timescale 1ns/1ps
`include "ate_map.svh"
module tb_acq_trigger_encoder_status
  import ate_pkg::*;
;
  logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, frame_end = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, cc_primary_in = 4'h0, cc_secondary_in = 4'h0;
  logic [3:0] cc_primary_out, cc_secondary_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, horizontal_counter_low_bits = 2'h0;
  logic [16:0] vertical_table_address = 17'h0_0000;
  logic [9:0] encoder_divider_m_param;
  logic [2:0] trigger_pins, encoder_pins;
  logic primary_pixel_clock, secondary_pixel_clock, acq_trigger, encoder_pulse;
  int fails = 0, n_compared = 0, enc_cnt = 0;

  ate_top uut (.*);
  ate_far_side src (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) if (encoder_pulse === 1'b1) enc_cnt <= enc_cnt + 1;

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic lost();
    fails++;
    wrap_up();
  endtask : lost

  // Ready lines stay high; a response is taken the edge it shows
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input ate_resp_t er);
    bit done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, er);
        done = 1;
      end
    end
    if (!done) lost();
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input ate_resp_t er);
    bit done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        done = 1;
      end
    end
    if (!done) lost();
  endtask : rd_chk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd_chk(8'h00, `ATE_CTRL_RST, 2'h0);
    rd_chk(8'h04, `ATE_RB_RST, 2'h0);
    rd_chk(8'h08, 32'h0000_0000, 2'h3);
    axi_wr(8'h0c, 32'hffff_ffff, 2'h3);
    axi_wr(8'h00, 32'hffff_ffff, 2'h0);
    rd_chk(8'h00, `ATE_CTRL_WMASK, 2'h0);
    chk(acq_trigger, 1'b1);
    vertical_table_address <= 17'h1_2345;
    horizontal_counter_low_bits <= 2'h2;
    axi_wr(8'h04, 32'hffff_ffff, 2'h0);
    rd_chk(8'h04, 32'h2ffe_0000, 2'h0);
    frame_end <= 1'b1;
    @(posedge aclk);
    frame_end <= 1'b0;
    vertical_table_address <= 17'h0_0042;
    rd_chk(8'h04, 32'h2fff_2345, 2'h0);
    axi_wr(8'h04, 32'h0000_0000, 2'h0);
    rd_chk(8'h04, 32'h2000_0042, 2'h0);
    // Software sees the low bits move between two reads
    horizontal_counter_low_bits <= 2'h1;
    rd_chk(8'h04, 32'h1000_0042, 2'h0);
  endtask : t_regs

  // Pin to output takes 3 edges; 5 leaves margin
  task automatic t_trig();
    src.set_trig(3'h2);
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b0);
    rd_chk(8'h04, 32'h5000_0042, 2'h0);
    axi_wr(8'h00, 32'h4000_0001, 2'h0);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b1);
    src.set_trig(3'h0);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b0);
    axi_wr(8'h00, 32'h0000_000c, 2'h0);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b1);
    // Gated pin with inverted polarity: a high pin must block the trigger
    axi_wr(8'h00, 32'h4000_0004, 2'h0);
    src.set_trig(3'h1);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b0);
    src.set_trig(3'h0);
    repeat (5) @(posedge aclk);
    chk(acq_trigger, 1'b1);
  endtask : t_trig

  task automatic t_enc();
    int c0;
    int rat[4] = '{5, 1, 0, 1};
    int pls[4] = '{10, 3, 3, 3};
    int exp[4] = '{2, 3, 3, 0};
    for (int i = 0; i < 4; i++) begin
      axi_wr(8'h00, (i < 3) ? 32'h8000_0000 : 32'h0000_0000, 2'h0);
      axi_wr(8'h04, 32'(rat[i]) << 18, 2'h0);
      c0 = enc_cnt;
      src.enc_pulses(pls[i]);
      repeat (6) @(posedge aclk);
      chk(32'(enc_cnt - c0), 32'(exp[i]));
    end
  endtask : t_enc

  // Entry: code, primary in, secondary in, pixel edge, expected outputs
  task automatic t_cc();
    logic [23:0] tab[7] = '{24'h25_a000, 24'h25_a25a, 24'h33_c13a, 24'h33_c23c,
                            24'h16_9169, 24'h0f_00f0, 24'h51_2012};
    foreach (tab[i]) begin
      axi_wr(8'h00, {2'b00, tab[i][22:20], 27'h000_0000}, 2'h0);
      cc_primary_in <= tab[i][19:16];
      cc_secondary_in <= tab[i][15:12];
      if (tab[i][9:8] != 2'h0) src.pix_pulse(tab[i][9:8]);
      repeat (8) @(posedge aclk);
      chk({cc_primary_out, cc_secondary_out}, tab[i][7:0]);
    end
  endtask : t_cc

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_trig();
    t_enc();
    t_cc();
    wrap_up();
  end
endmodule : tb_acq_trigger_encoder_status
